/* File: include/cbo_pkg.sv */
// types of the coherent barrier ordering block.
// assumes cbo_regs.svh supplies the field encodings.
package cbo_pkg;

   // life of one captured barrier on one address channel
   typedef enum logic [1:0] {
      SLOT_IDLE,
      SLOT_DRAIN,
      SLOT_RESP,
      SLOT_DONE
   } cbo_slot_state_t;

endpackage : cbo_pkg

/* File: include/cbo_regs.svh */
// constants of the coherent barrier ordering block: field encodings,
// domain codes and response values. assumes the pair of barriers of one
// master arrives on its read and write address channels.
// Function
// - memory barrier: later observed implies earlier observed
// - sync barrier completes once earlier transactions observable
// - system sync waits for earlier arrivals at slaves
// - read barrier answered on read data, no data
// - write barrier answered on write response, no data
// - channel traffic before its barrier counts before
// - after barrier only once both responses received
// - barrier-type field marks barrier versus normal
// - normal: barrier-type says respect or ignore
// - barrier: barrier-type says memory or sync
// - domain 00 orders only own stream
// - domain 01 orders inner shareable masters
// - domain 10 orders outer shareable masters
// - domain 11 orders whole system
// - system sync response waits for endpoint arrival
// - barrier response returns its id and OKAY
`ifndef CBO_REGS_SVH
`define CBO_REGS_SVH

// barrier-type field
`define CBO_BAR_W 2
`define CBO_BAR_NORMAL_RESPECT 2'h0
`define CBO_BAR_MEMORY 2'h1
`define CBO_BAR_NORMAL_IGNORE 2'h2
`define CBO_BAR_SYNC 2'h3
`define CBO_BAR_IS_BARRIER_BIT 0
`define CBO_BAR_SYNC_BIT 1

// shareability domain field
`define CBO_DOM_W 2
`define CBO_DOM_NONSHARE 2'h0
`define CBO_DOM_INNER 2'h1
`define CBO_DOM_OUTER 2'h2
`define CBO_DOM_SYSTEM 2'h3

// response field
`define CBO_RESP_W 2
`define CBO_RESP_OKAY 2'h0

`endif

/* File: tb/cbo_barrier_monitor.sv */
// concurrent checks on the ports of the barrier tracker.
// assumes single-beat downstream reads while a barrier is answered.
`timescale 1ns/1ps
`include "cbo_regs.svh"
module cbo_barrier_monitor #(
   parameter int ID_W = 4
) (
   // clock and reset
   input wire logic refClk,
   input wire logic srst,
   // upstream address
   input wire logic s_arvalid,
   input wire logic s_arready,
   input wire logic [ID_W-1:0] s_arid,
   input wire logic [1:0] s_arbar,
   input wire logic [1:0] s_ardomain,
   input wire logic s_awvalid,
   input wire logic s_awready,
   input wire logic [ID_W-1:0] s_awid,
   input wire logic [1:0] s_awbar,
   input wire logic [1:0] s_awdomain,
   // upstream answers
   input wire logic s_rvalid,
   input wire logic [ID_W-1:0] s_rid,
   input wire logic [1:0] s_rresp,
   input wire logic s_rlast,
   input wire logic s_bvalid,
   input wire logic [ID_W-1:0] s_bid,
   input wire logic [1:0] s_bresp,
   // downstream
   input wire logic m_arvalid,
   input wire logic [ID_W-1:0] m_arid,
   input wire logic m_awvalid,
   input wire logic m_rvalid,
   input wire logic m_bvalid,
   // status
   input wire logic barrierBusy
);
   default clocking cb @(posedge refClk); endclocking
   default disable iff (srst);
   // read barrier seen since the tracker was last idle
   logic rdHeld;
   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge refClk) begin
      if (srst) rdHeld <= 1'b0;
      else if (s_arvalid && s_arready && s_arbar[0]) rdHeld <= 1'b1;
      else if (!barrierBusy) rdHeld <= 1'b0;
   end
   sequence arTake;
      s_arvalid && s_arready && s_arbar[0];
   endsequence
   sequence awTake;
      s_awvalid && s_awready && s_awbar[0];
   endsequence
   ////////////////////////////////////////////////////////////////////////
   ar_not_fwd_a: assert property (
      s_arvalid && s_arbar[0] |-> !m_arvalid)
      else $error("read barrier forwarded downstream");
   aw_not_fwd_a: assert property (
      s_awvalid && s_awbar[0] |-> !m_awvalid)
      else $error("write barrier forwarded downstream");
   // a downstream beat in the way may delay the answer, so skip that case
   rbar_answer_a: assert property (
      arTake ##0 s_ardomain == 2'h0 ##1 !m_rvalid |-> s_rvalid &&
      s_rid == $past(s_arid) && s_rresp == `CBO_RESP_OKAY && s_rlast)
      else $error("read barrier answer wrong");
   bbar_answer_a: assert property (
      awTake ##0 s_awdomain == 2'h0 |=> s_bvalid &&
      s_bid == $past(s_awid) && s_bresp == `CBO_RESP_OKAY)
      else $error("write barrier answer wrong");
   rd_hold_a: assert property (
      rdHeld && barrierBusy && s_arvalid &&
      s_arbar == `CBO_BAR_NORMAL_RESPECT |-> !s_arready)
      else $error("respecting read passed a barrier");
   ign_pass_a: assert property (
      s_arvalid && s_arbar == `CBO_BAR_NORMAL_IGNORE |->
      m_arvalid && m_arid == s_arid)
      else $error("ignoring read not forwarded");
   busy_set_a: assert property (
      arTake |=> barrierBusy)
      else $error("busy low after barrier taken");
   pair_wait_a: assert property (
      awTake ##0 (s_awdomain != 2'h0 && !rdHeld &&
      !(s_arvalid && s_arready && s_arbar[0])) ##1 !m_bvalid |-> !s_bvalid)
      else $error("write barrier answered before its pair");
endmodule : cbo_barrier_monitor
bind cbo_barrier_tracker cbo_barrier_monitor #(.ID_W(ID_W)) mon (.*);

/* File: tb/cbo_barrier_tracker_bench.sv */
// self-checking bench: barrier tracker in front of the slave model.
// assumes single-beat transfers and barriers sent as read/write pairs.
`timescale 1ns/1ps
`include "cbo_regs.svh"
module cbo_barrier_tracker_bench;
   logic refClk = 1'b0;
   logic srst = 1'b1;
   logic [3:0] lat = 4'h0;
   logic s_arvalid = 1'b0, s_awvalid = 1'b0, s_wvalid = 1'b0;
   logic s_wlast = 1'b0, s_rready = 1'b0, s_bready = 1'b0;
   logic [3:0] s_arid = 4'h0, s_awid = 4'h0;
   logic [31:0] s_araddr = 32'h0, s_awaddr = 32'h0, s_wdata = 32'h0;
   logic [7:0] s_arlen = 8'h00, s_awlen = 8'h00;
   logic [1:0] s_arbar = 2'h0, s_ardomain = 2'h0;
   logic [1:0] s_awbar = 2'h0, s_awdomain = 2'h0;
   logic s_arready, s_awready, s_wready, s_rvalid, s_rlast, s_bvalid;
   logic [3:0] s_rid, s_bid, m_arid, m_awid, m_rid, m_bid;
   logic [31:0] s_rdata, m_araddr, m_awaddr, m_wdata, m_rdata;
   logic [7:0] m_arlen, m_awlen;
   logic [1:0] s_rresp, s_bresp, m_arbar, m_ardomain, m_awbar, m_awdomain;
   logic [1:0] m_rresp, m_bresp;
   logic m_arvalid, m_arready, m_awvalid, m_awready, m_wvalid, m_wready;
   logic m_wlast, m_rvalid, m_rready, m_rlast, m_bvalid, m_bready;
   logic barrierBusy;
   int badCount = 0;
   int nChecks = 0;
   always #2.5 refClk = ~refClk;
   cbo_barrier_tracker uut (.*);
   cbo_slave_model partner (.*);
   ////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      if (badCount == 0 && nChecks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : summarize
   task automatic chk(input string what, input logic [31:0] exp, got);
      nChecks++;
      if (got !== exp) begin
         badCount++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // a hang here is a fault of the tracker, so the run is closed
   task automatic hs(ref logic rdy);
      for (int i = 0; i < 300; i++) begin
         @(posedge refClk);
         if (rdy === 1'b1) return;
      end
      badCount++;
      summarize();
   endtask : hs
   task automatic arSet(input logic [3:0] id, input logic [1:0] bar, dom);
      @(posedge refClk);
      s_arvalid <= 1'b1;
      s_arid <= id;
      s_araddr <= {28'h000_0000, id};
      s_arbar <= bar;
      s_ardomain <= dom;
   endtask : arSet
   task automatic ar(input logic [3:0] id, input logic [1:0] bar, dom);
      arSet(id, bar, dom);
      hs(s_arready);
      s_arvalid <= 1'b0;
   endtask : ar
   task automatic aw(input logic [3:0] id, input logic [1:0] bar, dom);
      @(posedge refClk);
      s_awvalid <= 1'b1;
      s_awid <= id;
      s_awaddr <= {28'h000_0000, id};
      s_awbar <= bar;
      s_awdomain <= dom;
      hs(s_awready);
      s_awvalid <= 1'b0;
   endtask : aw
   task automatic rd(input logic [3:0] id, input logic [31:0] data,
         input bit isBar);
      @(posedge refClk);
      s_rready <= 1'b1;
      hs(s_rvalid);
      s_rready <= 1'b0;
      chk("s_rid", 32'(id), 32'(s_rid));
      chk("s_rresp", 32'(`CBO_RESP_OKAY), 32'(s_rresp));
      chk("s_rlast", 32'h1, 32'(s_rlast));
      if (!isBar) chk("s_rdata", data, s_rdata);
   endtask : rd
   task automatic wb(input logic [3:0] id);
      @(posedge refClk);
      s_bready <= 1'b1;
      hs(s_bvalid);
      s_bready <= 1'b0;
      chk("s_bid", 32'(id), 32'(s_bid));
      chk("s_bresp", 32'(`CBO_RESP_OKAY), 32'(s_bresp));
   endtask : wb
   ////////////////////////////////////////////////////////////////////////
   task automatic scNormal();
      ar(4'h1, `CBO_BAR_NORMAL_RESPECT, `CBO_DOM_INNER);
      rd(4'h1, 32'hFFFF_FFFE, 1'b0);
      aw(4'h2, `CBO_BAR_NORMAL_RESPECT, `CBO_DOM_INNER);
      @(posedge refClk);
      s_wvalid <= 1'b1;
      s_wdata <= 32'h1234_5678;
      s_wlast <= 1'b1;
      hs(s_wready);
      chk("m_wdata", 32'h1234_5678, m_wdata);
      s_wvalid <= 1'b0;
      wb(4'h2);
      ar(4'h6, `CBO_BAR_NORMAL_IGNORE, `CBO_DOM_OUTER);
      chk("m_arbar", 32'(`CBO_BAR_NORMAL_IGNORE), 32'(m_arbar));
      rd(4'h6, 32'hFFFF_FFF9, 1'b0);
   endtask : scNormal
   // every domain with memory then sync barriers, write half first
   task automatic scPairs();
      logic [1:0] bar;
      for (int k = 0; k < 8; k++) begin
         bar = k[2] ? `CBO_BAR_SYNC : `CBO_BAR_MEMORY;
         aw(k[3:0], bar, k[1:0]);
         ar(k[3:0], bar, k[1:0]);
         rd(k[3:0], 32'h0, 1'b1);
         wb(k[3:0]);
         repeat (2) @(posedge refClk);
         chk("barrierBusy", 32'h0, 32'(barrierBusy));
      end
   endtask : scPairs
   // slow slave: a system sync barrier waits for the earlier read
   task automatic scDrain();
      lat <= 4'hC;
      ar(4'h3, `CBO_BAR_NORMAL_RESPECT, `CBO_DOM_INNER);
      ar(4'h9, `CBO_BAR_SYNC, `CBO_DOM_SYSTEM);
      aw(4'h9, `CBO_BAR_SYNC, `CBO_DOM_SYSTEM);
      arSet(4'h5, `CBO_BAR_NORMAL_RESPECT, `CBO_DOM_INNER);
      repeat (3) @(posedge refClk);
      chk("s_arready", 32'h0, 32'(s_arready));
      rd(4'h3, 32'hFFFF_FFFC, 1'b0);
      rd(4'h9, 32'h0, 1'b1);
      wb(4'h9);
      hs(s_arready);
      s_arvalid <= 1'b0;
      rd(4'h5, 32'hFFFF_FFFA, 1'b0);
   endtask : scDrain
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge refClk);
      srst <= 1'b0;
      scNormal();
      scPairs();
      scDrain();
      summarize();
   end
endmodule : cbo_barrier_tracker_bench

/* File: tb/cbo_slave_model.sv */
// downstream slave: one read and one write in flight, answered after lat.
// assumes single-beat reads and one write beat per request.
`timescale 1ns/1ps
module cbo_slave_model (
   // clock and reset
   input wire logic refClk,
   input wire logic srst,
   // answer delay in cycles
   input wire logic [3:0] lat,
   // read side
   input wire logic m_arvalid,
   output logic m_arready,
   input wire logic [3:0] m_arid,
   input wire logic [31:0] m_araddr,
   output logic m_rvalid,
   input wire logic m_rready,
   output logic [3:0] m_rid,
   output logic [31:0] m_rdata,
   output logic [1:0] m_rresp,
   output logic m_rlast,
   // write side
   input wire logic m_awvalid,
   output logic m_awready,
   input wire logic [3:0] m_awid,
   input wire logic m_wvalid,
   output logic m_wready,
   input wire logic m_wlast,
   output logic m_bvalid,
   input wire logic m_bready,
   output logic [3:0] m_bid,
   output logic [1:0] m_bresp
);
   logic rdBusy, wrBusy, gotW;
   logic [3:0] rdCnt, wrCnt;
   logic [31:0] rdVal;
   assign m_arready = !rdBusy;
   assign m_awready = !wrBusy;
   assign m_wready = 1'b1;
   assign m_rresp = 2'h0;
   assign m_bresp = 2'h0;
   assign m_rvalid = rdBusy && rdCnt == 4'h0;
   assign m_rlast = m_rvalid;
   assign m_bvalid = wrBusy && gotW && wrCnt == 4'h0;
   // outside a beat the data lines flip, so stale data never matches
   assign m_rdata = m_rvalid ? rdVal : ~rdVal;
   always_ff @(posedge refClk) begin
      if (srst) begin
         rdBusy <= 1'b0;
         wrBusy <= 1'b0;
         gotW <= 1'b0;
         rdCnt <= 4'h0;
         wrCnt <= 4'h0;
      end else begin
         if (m_arvalid && m_arready) begin
            rdBusy <= 1'b1;
            rdCnt <= lat;
            m_rid <= m_arid;
            rdVal <= ~m_araddr;
         end else if (rdCnt != 4'h0) rdCnt <= rdCnt - 4'h1;
         else if (m_rvalid && m_rready) rdBusy <= 1'b0;
         if (m_awvalid && m_awready) begin
            wrBusy <= 1'b1;
            wrCnt <= lat;
            m_bid <= m_awid;
         end else if (wrCnt != 4'h0) wrCnt <= wrCnt - 4'h1;
         if (m_wvalid && m_wlast) gotW <= 1'b1;
         if (m_bvalid && m_bready) begin
            wrBusy <= 1'b0;
            gotW <= 1'b0;
         end
      end
   end
endmodule : cbo_slave_model

/* File: verilog/cbo_barrier_slot.sv */
// one captured barrier of an address channel: waits for the drain condition
// unless non-shareable, offers its response, then waits for the pair release.
// assumes capture is a handshake strobe and only taken while idle.
`timescale 1ns/1ps
`include "cbo_regs.svh"
module cbo_barrier_slot #(
   parameter int ID_W = 4
) (
   // clock and reset
   input wire logic refClk,
   input wire logic srst,
   // capture of a barrier
   input wire logic capture,
   input wire logic [ID_W-1:0] capId,
   input wire logic [`CBO_BAR_W-1:0] capBar,
   input wire logic [`CBO_DOM_W-1:0] capDomain,
   // pair progress
   input wire logic drained,
   input wire logic respAccept,
   input wire logic pairDone,
   // state
   output logic pending,
   output logic respValid,
   output logic done,
   output logic [ID_W-1:0] barId,
   output logic isSync,
   output logic [`CBO_DOM_W-1:0] domain
);

   cbo_pkg::cbo_slot_state_t state;
   cbo_pkg::cbo_slot_state_t next_state;
   wire logic localOnly;

   // non-shareable needs only stream order, which blocking gives
   assign localOnly = (capDomain == `CBO_DOM_NONSHARE);

   always_comb begin
      next_state = state;
      unique case (state)
         cbo_pkg::SLOT_IDLE: begin
            if (capture) begin
               next_state = localOnly ? cbo_pkg::SLOT_RESP
                                      : cbo_pkg::SLOT_DRAIN;
            end
         end
         cbo_pkg::SLOT_DRAIN: begin
            // every shared domain and system sync waits for endpoints
            if (drained) begin
               next_state = cbo_pkg::SLOT_RESP;
            end
         end
         cbo_pkg::SLOT_RESP: begin
            if (respAccept) begin
               next_state = cbo_pkg::SLOT_DONE;
            end
         end
         cbo_pkg::SLOT_DONE: begin
            if (pairDone) begin
               next_state = cbo_pkg::SLOT_IDLE;
            end
         end
      endcase
   end

   assign pending = (state != cbo_pkg::SLOT_IDLE);
   assign respValid = (state == cbo_pkg::SLOT_RESP);
   assign done = (state == cbo_pkg::SLOT_DONE);

   always_ff @(posedge refClk) begin
      if (srst) begin
         state <= cbo_pkg::SLOT_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge refClk) begin
      if (srst) begin
         barId <= '0;
         isSync <= 1'b0;
         domain <= `CBO_DOM_NONSHARE;
      end else if (capture) begin
         barId <= capId;
         isSync <= capBar[`CBO_BAR_SYNC_BIT];
         domain <= capDomain;
      end
   end

endmodule : cbo_barrier_slot

/* File: verilog/cbo_barrier_tracker.sv */
// barrier handling at the interconnect end of a coherent master port.
// barriers are terminated here and answered once ordering holds; normal
// traffic passes through to the downstream port.
// assumes downstream answers every forwarded transaction and never
// interleaves read bursts of different ids.
`timescale 1ns/1ps
`include "cbo_regs.svh"
module cbo_barrier_tracker #(
   parameter int ID_W = 4,
   parameter int ADDR_W = 32,
   parameter int DATA_W = 32,
   parameter int LEN_W = 8,
   parameter int CNT_W = 8
) (
   // clock and reset
   input wire logic refClk,
   input wire logic srst,
   // upstream read address
   input wire logic s_arvalid,
   output logic s_arready,
   input wire logic [ID_W-1:0] s_arid,
   input wire logic [ADDR_W-1:0] s_araddr,
   input wire logic [LEN_W-1:0] s_arlen,
   input wire logic [`CBO_BAR_W-1:0] s_arbar,
   input wire logic [`CBO_DOM_W-1:0] s_ardomain,
   // upstream write address
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [ID_W-1:0] s_awid,
   input wire logic [ADDR_W-1:0] s_awaddr,
   input wire logic [LEN_W-1:0] s_awlen,
   input wire logic [`CBO_BAR_W-1:0] s_awbar,
   input wire logic [`CBO_DOM_W-1:0] s_awdomain,
   // upstream write data
   input wire logic s_wvalid,
   output logic s_wready,
   input wire logic [DATA_W-1:0] s_wdata,
   input wire logic s_wlast,
   // upstream read data
   output logic s_rvalid,
   input wire logic s_rready,
   output logic [ID_W-1:0] s_rid,
   output logic [DATA_W-1:0] s_rdata,
   output logic [`CBO_RESP_W-1:0] s_rresp,
   output logic s_rlast,
   // upstream write response
   output logic s_bvalid,
   input wire logic s_bready,
   output logic [ID_W-1:0] s_bid,
   output logic [`CBO_RESP_W-1:0] s_bresp,
   // downstream read address
   output logic m_arvalid,
   input wire logic m_arready,
   output logic [ID_W-1:0] m_arid,
   output logic [ADDR_W-1:0] m_araddr,
   output logic [LEN_W-1:0] m_arlen,
   output logic [`CBO_BAR_W-1:0] m_arbar,
   output logic [`CBO_DOM_W-1:0] m_ardomain,
   // downstream write address
   output logic m_awvalid,
   input wire logic m_awready,
   output logic [ID_W-1:0] m_awid,
   output logic [ADDR_W-1:0] m_awaddr,
   output logic [LEN_W-1:0] m_awlen,
   output logic [`CBO_BAR_W-1:0] m_awbar,
   output logic [`CBO_DOM_W-1:0] m_awdomain,
   // downstream write data
   output logic m_wvalid,
   input wire logic m_wready,
   output logic [DATA_W-1:0] m_wdata,
   output logic m_wlast,
   // downstream read data
   input wire logic m_rvalid,
   output logic m_rready,
   input wire logic [ID_W-1:0] m_rid,
   input wire logic [DATA_W-1:0] m_rdata,
   input wire logic [`CBO_RESP_W-1:0] m_rresp,
   input wire logic m_rlast,
   // downstream write response
   input wire logic m_bvalid,
   output logic m_bready,
   input wire logic [ID_W-1:0] m_bid,
   input wire logic [`CBO_RESP_W-1:0] m_bresp,
   // status
   output logic barrierBusy
);

   ////////////////////////////////////////////////////////////////////////
   // decode of the barrier-type field

   wire logic arIsBarrier;
   wire logic awIsBarrier;
   wire logic arIgnores;
   wire logic awIgnores;

   assign arIsBarrier = s_arbar[`CBO_BAR_IS_BARRIER_BIT];
   assign awIsBarrier = s_awbar[`CBO_BAR_IS_BARRIER_BIT];
   assign arIgnores = (s_arbar == `CBO_BAR_NORMAL_IGNORE);
   assign awIgnores = (s_awbar == `CBO_BAR_NORMAL_IGNORE);

   ////////////////////////////////////////////////////////////////////////
   // barrier slots, outstanding counters and pair release

   wire logic rdPend;
   wire logic wrPend;
   wire logic rdRespValid;
   wire logic wrRespValid;
   wire logic rdDone;
   wire logic wrDone;
   wire logic [ID_W-1:0] rdBarId;
   wire logic [ID_W-1:0] wrBarId;
   wire logic rdEmpty;
   wire logic wrEmpty;
   wire logic rdFull;
   wire logic wrFull;
   wire logic drained;
   wire logic pairRelease;
   wire logic rdCapture;
   wire logic wrCapture;
   wire logic rdBarAccept;
   wire logic wrBarAccept;
   wire logic arFwd;
   wire logic awFwd;
   wire logic rdRetire;
   wire logic wrRetire;

   // earlier traffic on either channel is only known complete once both
   // barriers are in, so the drain waits for the whole pair
   assign drained = rdPend && wrPend && rdEmpty && wrEmpty;
   assign pairRelease = rdDone && wrDone;
   assign rdCapture = s_arvalid && arIsBarrier && !rdPend;
   assign wrCapture = s_awvalid && awIsBarrier && !wrPend;

   cbo_barrier_slot #(
      .ID_W(ID_W)
   ) u_rdSlot (
      .refClk(refClk),
      .srst(srst),
      .capture(rdCapture),
      .capId(s_arid),
      .capBar(s_arbar),
      .capDomain(s_ardomain),
      .drained(drained),
      .respAccept(rdBarAccept),
      .pairDone(pairRelease),
      .pending(rdPend),
      .respValid(rdRespValid),
      .done(rdDone),
      .barId(rdBarId),
      .isSync(),
      .domain()
   );

   cbo_barrier_slot #(
      .ID_W(ID_W)
   ) u_wrSlot (
      .refClk(refClk),
      .srst(srst),
      .capture(wrCapture),
      .capId(s_awid),
      .capBar(s_awbar),
      .capDomain(s_awdomain),
      .drained(drained),
      .respAccept(wrBarAccept),
      .pairDone(pairRelease),
      .pending(wrPend),
      .respValid(wrRespValid),
      .done(wrDone),
      .barId(wrBarId),
      .isSync(),
      .domain()
   );

   // counts end at the downstream answer, i.e. arrival at the endpoint.
   // ignoring traffic is counted too: simpler, may delay a drain
   cbo_txn_counter #(
      .WIDTH(CNT_W)
   ) u_rdCnt (
      .refClk(refClk),
      .srst(srst),
      .up(m_arvalid && m_arready),
      .down(rdRetire),
      .empty(rdEmpty),
      .full(rdFull)
   );

   cbo_txn_counter #(
      .WIDTH(CNT_W)
   ) u_wrCnt (
      .refClk(refClk),
      .srst(srst),
      .up(m_awvalid && m_awready),
      .down(wrRetire),
      .empty(wrEmpty),
      .full(wrFull)
   );

   assign barrierBusy = rdPend || wrPend;

   ////////////////////////////////////////////////////////////////////////
   // address channels: barriers stop here, normal traffic passes unless
   // held behind this channel's barrier

   // a second barrier waits until the pair before it is released
   assign arFwd = s_arvalid && !arIsBarrier && !rdFull &&
                  (!rdPend || arIgnores);
   assign awFwd = s_awvalid && !awIsBarrier && !wrFull &&
                  (!wrPend || awIgnores);

   assign m_arvalid = arFwd;
   assign m_arid = s_arid;
   assign m_araddr = s_araddr;
   assign m_arlen = s_arlen;
   assign m_arbar = s_arbar;
   assign m_ardomain = s_ardomain;
   assign s_arready = arIsBarrier ? !rdPend : (arFwd && m_arready);

   assign m_awvalid = awFwd;
   assign m_awid = s_awid;
   assign m_awaddr = s_awaddr;
   assign m_awlen = s_awlen;
   assign m_awbar = s_awbar;
   assign m_awdomain = s_awdomain;
   assign s_awready = awIsBarrier ? !wrPend : (awFwd && m_awready);

   // barrier writes own no data beats, so every beat is a normal write's
   assign m_wvalid = s_wvalid;
   assign m_wdata = s_wdata;
   assign m_wlast = s_wlast;
   assign s_wready = m_wready;

   ////////////////////////////////////////////////////////////////////////
   // read data: barrier answer slotted in between downstream bursts

   logic rdMidBurst;
   wire logic rdBarSel;

   assign rdBarSel = rdRespValid && !rdMidBurst;
   assign rdBarAccept = rdBarSel && s_rready;
   assign rdRetire = m_rvalid && m_rready && m_rlast;

   assign s_rvalid = rdBarSel || m_rvalid;
   assign m_rready = s_rready && !rdBarSel;
   assign s_rid = rdBarSel ? rdBarId : m_rid;
   // read barrier answer carries no meaningful data
   assign s_rdata = rdBarSel ? '0 : m_rdata;
   assign s_rresp = rdBarSel ? `CBO_RESP_OKAY : m_rresp;
   assign s_rlast = rdBarSel ? 1'b1 : m_rlast;

   always_ff @(posedge refClk) begin
      if (srst) begin
         rdMidBurst <= 1'b0;
      end else if (m_rvalid && m_rready) begin
         rdMidBurst <= !m_rlast;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // write response: barrier answer takes priority over downstream

   wire logic wrBarSel;

   assign wrBarSel = wrRespValid;
   assign wrBarAccept = wrBarSel && s_bready;
   assign wrRetire = m_bvalid && m_bready;

   assign s_bvalid = wrBarSel || m_bvalid;
   assign m_bready = s_bready && !wrBarSel;
   assign s_bid = wrBarSel ? wrBarId : m_bid;
   assign s_bresp = wrBarSel ? `CBO_RESP_OKAY : m_bresp;

endmodule : cbo_barrier_tracker

/* File: verilog/cbo_txn_counter.sv */
// counter of transactions issued downstream and not yet answered.
// assumes up and down are single-cycle handshake strobes.
`timescale 1ns/1ps
module cbo_txn_counter #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input wire logic refClk,
   input wire logic srst,
   // events
   input wire logic up,
   input wire logic down,
   // state
   output logic empty,
   output logic full
);

   logic [WIDTH-1:0] count;
   logic [WIDTH-1:0] next_count;
   wire logic [WIDTH-1:0] one = {{(WIDTH-1){1'b0}}, 1'b1};

   assign next_count = (up && !down) ? count + one :
                       (down && !up) ? count - one : count;
   assign empty = (count == '0);
   assign full = (count == '1);

   always_ff @(posedge refClk) begin
      if (srst) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end

endmodule : cbo_txn_counter
